// *** logic/hrs_defines.svh ***
// Register offsets, field positions and reset values of the return stack
`ifndef HRS_DEFINES_SVH
`define HRS_DEFINES_SVH
`define HRS_OFS_PWRCTL 8'h00
`define HRS_OFS_MASK 8'h04
`define HRS_OFS_CTRL 8'h08
`define HRS_OFS_PTR 8'h0C
`define HRS_OFS_TOP_LO 8'h10
`define HRS_OFS_TOP_HI 8'h14
`define HRS_BIT_OVF 7
`define HRS_BIT_UNF 6
`define HRS_BIT_OVF_RST_EN 0
`define HRS_PTR_RESET 5'h1F
`define HRS_PTR_FULL 5'h0F
`define HRS_PTR_EMPTY 5'h1F
`define HRS_RESP_OKAY 2'h0
`define HRS_RESP_SLVERR 2'h2
`endif

// *** logic/hrs_pkg.sv ***
// Types shared by the return stack logic
package hrs_pkg;
	typedef enum logic [2:0] {
		HRS_SEL_PWRCTL,
		HRS_SEL_MASK,
		HRS_SEL_CTRL,
		HRS_SEL_PTR,
		HRS_SEL_TOP_LO,
		HRS_SEL_TOP_HI,
		HRS_SEL_NONE
	} hrs_sel_type;
	typedef logic [14:0] hrs_pc_type;
endpackage

// *** logic/hrs_stack.sv ***
// Hardware return-address stack with AXI4-Lite register access
//
// The address map and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`include "hrs_defines.svh"

// Operation
// - Sixteen entries of fifteen bits, apart from program and data space.
// - Calls, calls via working register and interrupts push the PC.
// - Return, return with literal and return from interrupt pop.
// - Push and pop leave the PC high latch untouched.
// - With reset-on-overflow off the stack wraps circularly.
// - Overflow and underflow set their flags regardless of reset option.
// - Top-of-stack registers read and write the entry the pointer selects.
// - Top-of-stack value split into a high and a low register.
// - Pointer is five bits to detect overflow and underflow.
// - Calls and interrupts increment the pointer, returns decrement it.
// - Push increments then writes; pop reads then decrements.
// - Push and pop happen only as side effects of core events.
module hrs_stack
	import hrs_pkg::*;
#(
	parameter int DEPTH = 16,
	parameter int PC_W = 15
) (
	input logic CORE_CLK_I,
	input logic SYS_RST_I,
	input logic CALL_PUSH_I,
	input logic RET_POP_I,
	input logic [PC_W-1:0] PC_I,
	output logic [PC_W-1:0] RET_PC_O,
	output logic RET_VALID_O,
	output logic RESET_REQ_O,
	output logic [4:0] STACK_PTR_O,
	output logic IRQ_O,
	input logic [31:0] S_AXI_AWADDR,
	input logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input logic [31:0] S_AXI_WDATA,
	input logic [3:0] S_AXI_WSTRB,
	input logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input logic S_AXI_BREADY,
	input logic [31:0] S_AXI_ARADDR,
	input logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input logic S_AXI_RREADY
);

	// Stack storage, outside every other address space
	logic [PC_W-1:0] stack_mem [DEPTH];

	logic [4:0] ptr_r;
	logic [4:0] ptr_nxt;
	logic [1:0] flag_r;
	logic [1:0] flag_nxt;
	logic [1:0] mask_r;
	logic ovf_rst_en_r;
	logic [PC_W-1:0] ret_pc_r;
	logic ret_valid_r;
	logic reset_req_r;
	logic irq_r;

	logic awready_r;
	logic wready_r;
	logic aw_full_r;
	logic w_full_r;
	logic [7:0] awaddr_r;
	logic [7:0] wdata_r;
	logic wstrb0_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic arready_r;
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;

	logic push;
	logic pop;
	logic ovf_evt;
	logic unf_evt;
	logic do_write;
	logic wr_en;
	hrs_sel_type wsel;
	hrs_sel_type rsel;
	logic [3:0] idx;
	logic [PC_W-1:0] top_val;

	// Maps a byte address to the register it selects
	function automatic hrs_sel_type reg_sel(input logic [31:0] addr);
		hrs_sel_type s;
		s = HRS_SEL_NONE;
		if (addr[31:8] == 24'h000000) begin
			unique case (addr[7:0])
				`HRS_OFS_PWRCTL: s = HRS_SEL_PWRCTL;
				`HRS_OFS_MASK: s = HRS_SEL_MASK;
				`HRS_OFS_CTRL: s = HRS_SEL_CTRL;
				`HRS_OFS_PTR: s = HRS_SEL_PTR;
				`HRS_OFS_TOP_LO: s = HRS_SEL_TOP_LO;
				`HRS_OFS_TOP_HI: s = HRS_SEL_TOP_HI;
				default: s = HRS_SEL_NONE;
			endcase
		end
		return s;
	endfunction

	// Only core events move the stack; no register write pushes or pops
	assign push = CALL_PUSH_I;
	assign pop = RET_POP_I & ~CALL_PUSH_I;
	assign ovf_evt = push & (ptr_r == `HRS_PTR_FULL);
	assign unf_evt = pop & (ptr_r == `HRS_PTR_EMPTY);

	assign idx = ptr_r[3:0];
	assign top_val = stack_mem[idx];

	assign do_write = aw_full_r & w_full_r & ~bvalid_r;
	assign wsel = reg_sel({24'h000000, awaddr_r});
	assign rsel = reg_sel(S_AXI_ARADDR);
	// Core activity wins over a register write in the same cycle
	assign wr_en = do_write & wstrb0_r & ~push & ~pop;

	// Pointer: up on push, down on pop, wraps through all five bits
	always_comb begin
		ptr_nxt = ptr_r;
		if (push) begin
			ptr_nxt = ptr_r + 5'h01;
		end else if (pop) begin
			ptr_nxt = ptr_r - 5'h01;
		end else if (wr_en && wsel == HRS_SEL_PTR) begin
			ptr_nxt = wdata_r[4:0];
		end
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I) begin
			ptr_r <= `HRS_PTR_RESET;
		end else begin
			ptr_r <= ptr_nxt;
		end
	end

	// Push writes at the incremented pointer; low bits wrap the
	// seventeenth push onto the first entry
	always_ff @(posedge CORE_CLK_I) begin
		if (push) begin
			stack_mem[ptr_nxt[3:0]] <= PC_I;
		end else if (wr_en && wsel == HRS_SEL_TOP_LO) begin
			stack_mem[idx][7:0] <= wdata_r;
		end else if (wr_en && wsel == HRS_SEL_TOP_HI) begin
			stack_mem[idx][PC_W-1:8] <= wdata_r[PC_W-9:0];
		end
	end

	// Pop hands back the current entry before the pointer drops.
	// No path here reaches the PC high latch.
	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I) begin
			ret_pc_r <= '0;
			ret_valid_r <= 1'b0;
		end else begin
			ret_valid_r <= pop;
			if (pop) begin
				ret_pc_r <= top_val;
			end
		end
	end

	// Sticky flags; a new event beats a write-one-to-clear
	always_comb begin
		flag_nxt = flag_r;
		if (wr_en && wsel == HRS_SEL_PWRCTL) begin
			flag_nxt = flag_r & ~{wdata_r[`HRS_BIT_OVF],
				wdata_r[`HRS_BIT_UNF]};
		end
		if (ovf_evt) begin
			flag_nxt[1] = 1'b1;
		end
		if (unf_evt) begin
			flag_nxt[0] = 1'b1;
		end
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I) begin
			flag_r <= 2'h0;
			irq_r <= 1'b0;
		end else begin
			flag_r <= flag_nxt;
			irq_r <= |(flag_nxt & mask_r);
		end
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I) begin
			mask_r <= 2'h0;
			ovf_rst_en_r <= 1'b0;
		end else if (wr_en) begin
			if (wsel == HRS_SEL_MASK) begin
				mask_r <= {wdata_r[`HRS_BIT_OVF], wdata_r[`HRS_BIT_UNF]};
			end
			if (wsel == HRS_SEL_CTRL) begin
				ovf_rst_en_r <= wdata_r[`HRS_BIT_OVF_RST_EN];
			end
		end
	end

	// Reset request pulse on overflow or underflow when the reset-on-overflow option is set
	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I) begin
			reset_req_r <= 1'b0;
		end else begin
			reset_req_r <= ovf_rst_en_r & (ovf_evt | unf_evt);
		end
	end

	// Write address and data are taken independently, then joined
	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I) begin
			awready_r <= 1'b0;
			aw_full_r <= 1'b0;
			awaddr_r <= 8'h00;
		end else if (S_AXI_AWVALID && awready_r) begin
			awready_r <= 1'b0;
			aw_full_r <= 1'b1;
			awaddr_r <= S_AXI_AWADDR[7:0];
		end else if (bvalid_r && S_AXI_BREADY) begin
			awready_r <= 1'b1;
			aw_full_r <= 1'b0;
		end else if (!aw_full_r) begin
			awready_r <= 1'b1;
		end
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I) begin
			wready_r <= 1'b0;
			w_full_r <= 1'b0;
			wdata_r <= 8'h00;
			wstrb0_r <= 1'b0;
		end else if (S_AXI_WVALID && wready_r) begin
			wready_r <= 1'b0;
			w_full_r <= 1'b1;
			wdata_r <= S_AXI_WDATA[7:0];
			wstrb0_r <= S_AXI_WSTRB[0];
		end else if (bvalid_r && S_AXI_BREADY) begin
			wready_r <= 1'b1;
			w_full_r <= 1'b0;
		end else if (!w_full_r) begin
			wready_r <= 1'b1;
		end
	end

	// Answer; unmapped low-byte offsets give an error, upper write address bits are not kept
	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I) begin
			bvalid_r <= 1'b0;
			bresp_r <= `HRS_RESP_OKAY;
		end else if (do_write) begin
			bvalid_r <= 1'b1;
			bresp_r <= (wsel == HRS_SEL_NONE) ?
				`HRS_RESP_SLVERR : `HRS_RESP_OKAY;
		end else if (bvalid_r && S_AXI_BREADY) begin
			bvalid_r <= 1'b0;
		end
	end

	// Read channel: one-cycle answer, snapshot of the live state
	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= `HRS_RESP_OKAY;
		end else if (S_AXI_ARVALID && arready_r) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b1;
			rresp_r <= `HRS_RESP_OKAY;
			rdata_r <= 32'h00000000;
			unique case (rsel)
				HRS_SEL_PWRCTL: begin
					rdata_r[`HRS_BIT_OVF] <= flag_r[1];
					rdata_r[`HRS_BIT_UNF] <= flag_r[0];
				end
				HRS_SEL_MASK: begin
					rdata_r[`HRS_BIT_OVF] <= mask_r[1];
					rdata_r[`HRS_BIT_UNF] <= mask_r[0];
				end
				HRS_SEL_CTRL: rdata_r[`HRS_BIT_OVF_RST_EN] <= ovf_rst_en_r;
				HRS_SEL_PTR: rdata_r[4:0] <= ptr_r;
				HRS_SEL_TOP_LO: rdata_r[7:0] <= top_val[7:0];
				HRS_SEL_TOP_HI: rdata_r[PC_W-9:0] <= top_val[PC_W-1:8];
				HRS_SEL_NONE: rresp_r <= `HRS_RESP_SLVERR;
			endcase
		end else if (rvalid_r && S_AXI_RREADY) begin
			rvalid_r <= 1'b0;
			arready_r <= 1'b1;
		end else if (!rvalid_r) begin
			arready_r <= 1'b1;
		end
	end

	assign RET_PC_O = ret_pc_r;
	assign RET_VALID_O = ret_valid_r;
	assign RESET_REQ_O = reset_req_r;
	assign STACK_PTR_O = ptr_r;
	assign IRQ_O = irq_r;
	assign S_AXI_AWREADY = awready_r;
	assign S_AXI_WREADY = wready_r;
	assign S_AXI_BVALID = bvalid_r;
	assign S_AXI_BRESP = bresp_r;
	assign S_AXI_ARREADY = arready_r;
	assign S_AXI_RVALID = rvalid_r;
	assign S_AXI_RDATA = rdata_r;
	assign S_AXI_RRESP = rresp_r;

endmodule

// *** dv/hrs_stack_props.sv ***
// Assertion checker on the return stack ports
`timescale 1ns/1ps
module hrs_stack_props #(
	parameter int PC_W = 15
) (
	input wire logic CORE_CLK_I,
	input wire logic SYS_RST_I,
	input wire logic CALL_PUSH_I,
	input wire logic RET_POP_I,
	input wire logic [PC_W-1:0] PC_I,
	input wire logic [PC_W-1:0] RET_PC_O,
	input wire logic RET_VALID_O,
	input wire logic RESET_REQ_O,
	input wire logic [4:0] STACK_PTR_O,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [1:0] S_AXI_BRESP,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic [31:0] S_AXI_RDATA
);
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (SYS_RST_I);
	wire logic pop = RET_POP_I & ~CALL_PUSH_I;
	push_inc_a: assert property (
		CALL_PUSH_I |=> STACK_PTR_O == $past(STACK_PTR_O) + 5'h01)
		else $error("pointer not incremented");
	pop_dec_a: assert property (
		pop |=> STACK_PTR_O == $past(STACK_PTR_O) - 5'h01)
		else $error("pointer not decremented");
	push_pop_a: assert property (
		CALL_PUSH_I ##1 pop |=> RET_VALID_O && RET_PC_O == $past(PC_I, 2))
		else $error("popped value differs");
	pop_pulse_a: assert property (
		!pop |=> !RET_VALID_O && $stable(RET_PC_O))
		else $error("return output without pop");
	idle_ptr_a: assert property (
		!CALL_PUSH_I && !RET_POP_I ##1 !$rose(S_AXI_BVALID)
		|-> $stable(STACK_PTR_O))
		else $error("pointer moved while idle");
	reset_cause_a: assert property (
		RESET_REQ_O |-> $past(CALL_PUSH_I && STACK_PTR_O == 5'h0F
		|| pop && STACK_PTR_O == 5'h1F))
		else $error("reset request without cause");
	bresp_hold_a: assert property (
		S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
		else $error("write response dropped");
	rdata_hold_a: assert property (
		S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
		else $error("read data dropped");
	cover property (CALL_PUSH_I && STACK_PTR_O == 5'h0F);
	cover property (pop && STACK_PTR_O == 5'h1F);
	cover property (RESET_REQ_O);
	cover property (CALL_PUSH_I ##1 pop);
endmodule
bind hrs_stack hrs_stack_props #(.PC_W(PC_W)) u_props (.*);

// *** dv/hrs_core_model.sv ***
// Core sequencer model issuing pushes and pops
`timescale 1ns/1ps
module hrs_core_model (
	input wire logic clk_i,
	output logic push_o,
	output logic pop_o,
	output logic [14:0] pc_o
);
	initial begin
		push_o = 1'b0;
		pop_o = 1'b0;
		pc_o = 15'h0000;
	end
	// Back-to-back calls, one push a cycle
	task calls(input int n, input logic [14:0] pc0);
		for (int k = 0; k < n; k++) begin
			@(posedge clk_i);
			push_o <= 1'b1;
			pc_o <= pc0 + 15'(k);
		end
		@(posedge clk_i);
		push_o <= 1'b0;
		pc_o <= ~pc_o;
	endtask
	task rets(input int n);
		repeat (n) begin
			@(posedge clk_i);
			pop_o <= 1'b1;
		end
		@(posedge clk_i);
		pop_o <= 1'b0;
	endtask
	// A call whose return comes in the very next cycle
	task call_ret(input logic [14:0] pc);
		@(posedge clk_i);
		push_o <= 1'b1;
		pc_o <= pc;
		@(posedge clk_i);
		push_o <= 1'b0;
		pop_o <= 1'b1;
		@(posedge clk_i);
		pop_o <= 1'b0;
	endtask
endmodule

// *** dv/hrs_stack_test.sv ***
// Testbench of the return stack
`timescale 1ns/1ps
`include "hrs_defines.svh"
`define CK(n, e, s) begin n_checks++; if ((s) !== (e)) begin error_cnt++; \
$display("BAD %s exp %h got %h", n, e, s); end end
module hrs_stack_test;
	logic CORE_CLK_I, SYS_RST_I, CALL_PUSH_I, RET_POP_I, RET_VALID_O;
	logic RESET_REQ_O, IRQ_O, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID;
	logic S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID;
	logic S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
	logic [14:0] PC_I, RET_PC_O;
	logic [4:0] STACK_PTR_O;
	logic [3:0] S_AXI_WSTRB;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP, rsp;
	logic [31:0] S_AXI_AWADDR, S_AXI_WDATA, S_AXI_ARADDR, S_AXI_RDATA, d;
	int error_cnt, n_checks, cyc, rr_cnt;
	hrs_stack dut (.*);
	hrs_core_model core (.clk_i(CORE_CLK_I), .push_o(CALL_PUSH_I),
		.pop_o(RET_POP_I), .pc_o(PC_I));
	initial begin
		CORE_CLK_I = 1'b0;
		forever #2 CORE_CLK_I = ~CORE_CLK_I;
	end
	always @(posedge CORE_CLK_I) begin
		cyc++;
		if (RESET_REQ_O === 1'b1) rr_cnt++;
		if (cyc == 20000) begin
			error_cnt++;
			stop_test();
		end
	end
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge CORE_CLK_I);
		S_AXI_AWADDR <= {24'h0, a};
		S_AXI_WDATA <= v;
		S_AXI_AWVALID <= 1'b1;
		S_AXI_WVALID <= 1'b1;
		S_AXI_BREADY <= 1'b1;
		// Each channel drops its valid at its own handshake edge
		do begin
			@(posedge CORE_CLK_I);
			if (S_AXI_AWREADY === 1'b1) S_AXI_AWVALID <= 1'b0;
			if (S_AXI_WREADY === 1'b1) S_AXI_WVALID <= 1'b0;
		end while (S_AXI_BVALID !== 1'b1);
		S_AXI_BREADY <= 1'b0;
		rsp = S_AXI_BRESP;
	endtask
	task rd(input logic [7:0] a);
		@(posedge CORE_CLK_I);
		S_AXI_ARADDR <= {24'h0, a};
		S_AXI_ARVALID <= 1'b1;
		do @(posedge CORE_CLK_I); while (S_AXI_ARREADY !== 1'b1);
		S_AXI_ARVALID <= 1'b0;
		repeat (2) @(posedge CORE_CLK_I);
		S_AXI_RREADY <= 1'b1;
		do @(posedge CORE_CLK_I); while (S_AXI_RVALID !== 1'b1);
		S_AXI_RREADY <= 1'b0;
		d = S_AXI_RDATA;
		rsp = S_AXI_RRESP;
	endtask
	task rck(input string n, input logic [7:0] a, input logic [7:0] e);
		rd(a);
		`CK(n, {24'h0, e}, d);
	endtask
	task pop_chk(input logic [14:0] e);
		core.rets(1);
		#1;
		`CK("valid", 1'b1, RET_VALID_O);
		`CK("ret pc", e, RET_PC_O);
	endtask
	task t_regs();
		rck("ptr", `HRS_OFS_PTR, 8'h1F);
		rck("ctrl", `HRS_OFS_CTRL, 8'h00);
		rd(8'h40);
		`CK("rresp", `HRS_RESP_SLVERR, rsp);
		wr(8'h40, 32'h0000_00FF);
		`CK("bresp", `HRS_RESP_SLVERR, rsp);
		S_AXI_WSTRB <= 4'h0;
		wr(`HRS_OFS_PTR, 32'h0000_0005);
		S_AXI_WSTRB <= 4'hF;
		rck("ptr kept", `HRS_OFS_PTR, 8'h1F);
	endtask
	task t_b2b();
		core.call_ret(15'h2345);
		#1;
		`CK("b2b valid", 1'b1, RET_VALID_O);
		`CK("b2b pc", 15'h2345, RET_PC_O);
		`CK("b2b ptr", 5'h1F, STACK_PTR_O);
	endtask
	task t_lifo();
		core.calls(3, 15'h1230);
		#1;
		`CK("ptr", 5'h02, STACK_PTR_O);
		pop_chk(15'h1232);
		pop_chk(15'h1231);
		pop_chk(15'h1230);
		`CK("ptr", 5'h1F, STACK_PTR_O);
	endtask
	task t_wrap();
		wr(`HRS_OFS_MASK, 32'h0000_00C0);
		core.calls(17, 15'h4000);
		#1;
		`CK("ptr", 5'h10, STACK_PTR_O);
		rck("flags", `HRS_OFS_PWRCTL, 8'h80);
		`CK("irq", 1'b1, IRQ_O);
		`CK("rst req", 0, rr_cnt);
		rck("top lo", `HRS_OFS_TOP_LO, 8'h10);
		rck("top hi", `HRS_OFS_TOP_HI, 8'h40);
		pop_chk(15'h4010);
		pop_chk(15'h400F);
		wr(`HRS_OFS_PWRCTL, 32'h0000_0080);
		rck("flags", `HRS_OFS_PWRCTL, 8'h00);
		`CK("irq", 1'b0, IRQ_O);
	endtask
	task t_unf();
		wr(`HRS_OFS_CTRL, 32'h0000_0001);
		wr(`HRS_OFS_PTR, 32'h0000_001F);
		core.rets(1);
		#1;
		`CK("ptr", 5'h1E, STACK_PTR_O);
		rck("flags", `HRS_OFS_PWRCTL, 8'h40);
		`CK("rst req", 1, rr_cnt);
		wr(`HRS_OFS_MASK, 32'h0000_0000);
		#1;
		`CK("irq", 1'b0, IRQ_O);
		wr(`HRS_OFS_PWRCTL, 32'h0000_0040);
		wr(`HRS_OFS_CTRL, 32'h0000_0000);
	endtask
	task t_top();
		wr(`HRS_OFS_PTR, 32'h0000_0003);
		wr(`HRS_OFS_TOP_LO, 32'h0000_00A5);
		wr(`HRS_OFS_TOP_HI, 32'h0000_003C);
		rck("top hi", `HRS_OFS_TOP_HI, 8'h3C);
		pop_chk(15'h3CA5);
	endtask
	task stop_test();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		{S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} = 3'h0;
		{S_AXI_ARVALID, S_AXI_RREADY} = 2'h0;
		{S_AXI_AWADDR, S_AXI_WDATA, S_AXI_ARADDR} = 96'h0;
		S_AXI_WSTRB = 4'hF;
		SYS_RST_I = 1'b1;
		repeat (16) @(posedge CORE_CLK_I);
		SYS_RST_I <= 1'b0;
		t_regs();
		t_lifo();
		t_b2b();
		t_wrap();
		t_unf();
		t_top();
		stop_test();
	end
endmodule
